// *** dv/rng_osc_model.sv ***
// External oscillator pair feeding the two oscillator pins.
// Noise clock rests low while run is low, so no stray edges.
`timescale 1ns/1ps
module rng_osc_model #(
  parameter int HALF = 4
) (
  // Control
  input  wire logic clk,
  input  wire logic run,
  input  wire logic fast_lvl,
  // Pin drive
  output logic      noise,
  output logic      fast
);
  int cnt = 0;
  initial noise = 1'b0;
  assign fast = fast_lvl;
  always @(posedge clk) begin
    if (!run) begin
      noise <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      noise <= !noise;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// *** dv/rng_props.sv ***
// Port-level checker for the random source top.
// Bound to rng_top; sees its ports only.
`timescale 1ns/1ps
module rng_props import rng_pkg::*; #(
  parameter int NOISE_HALF = 4
) (
  // Clock and reset
  input wire logic         CLK_SYS,
  input wire logic         RST,
  // Oscillator pins
  input wire logic         FAST_OSC_SELECT,
  input wire logic         FAST_OSC_O,
  input wire logic         FAST_OSC_OE,
  input wire logic         NOISE_SOURCE_SELECT,
  input wire logic         PHASE_NOISE_OSC_I,
  input wire logic         PHASE_NOISE_OSC_O,
  input wire logic         PHASE_NOISE_OSC_OE,
  // Flags
  input wire logic         SAMPLED_BIT_TEST,
  input wire logic         TEST_STROBE,
  input wire logic         BYTE_READY_FLAG_N,
  input wire logic         ALARM_N,
  // Register bus
  input rng_apb_req_type   APB_REQ,
  input rng_apb_rsp_type   APB_RSP
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic        noise_sel;
  logic        mrst_wr;
  logic        noise_prev_ff;
  logic [31:0] hi_rise_ff;
  assign noise_sel = NOISE_SOURCE_SELECT ? PHASE_NOISE_OSC_I : PHASE_NOISE_OSC_O;
  assign mrst_wr = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && APB_REQ.paddr == 8'h04 && APB_REQ.pwdata[7];
  // Noise rises seen while the strobe is high; counting edges, not cycles, stays true across
  // a source switch or a master reset restart; a full buffer only adds rises, hence at least 16
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      noise_prev_ff <= 1'b0;
    end else begin
      noise_prev_ff <= noise_sel;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (RST || !TEST_STROBE) begin
      hi_rise_ff <= 32'h0;
    end else if (noise_sel && !noise_prev_ff) begin
      hi_rise_ff <= hi_rise_ff + 32'h1;
    end
  end
  a_fast_oe: assert property (FAST_OSC_OE == !FAST_OSC_SELECT) else $error("fast pin drive wrong");
  a_noise_oe: assert property (PHASE_NOISE_OSC_OE == !NOISE_SOURCE_SELECT) else $error("noise pin drive wrong");
  a_fast_toggles: assert property (FAST_OSC_OE |=> FAST_OSC_O != $past(FAST_OSC_O)) else $error("fast osc stuck");
  a_sample_edge: assert property ($changed(SAMPLED_BIT_TEST) |->
    $past(noise_sel) || $past(noise_sel, 2) || $past(noise_sel, 3)) else $error("sample without noise edge");
  a_ready_follow: assert property (APB_RSP.pready == APB_REQ.penable) else $error("pready wrong");
  a_err_access: assert property (APB_RSP.pslverr |-> APB_REQ.psel && APB_REQ.penable) else $error("stray error");
  a_err_alarm: assert property (APB_RSP.pslverr |-> ##[1:2] !ALARM_N) else $error("bus error gave no alarm");
  a_alarm_sticky: assert property (!ALARM_N && !mrst_wr |=> !ALARM_N) else $error("alarm cleared");
  a_mreset_clear: assert property (mrst_wr |=> ALARM_N && BYTE_READY_FLAG_N) else $error("master reset weak");
  a_strobe_high: assert property ($fell(TEST_STROBE) |-> hi_rise_ff >= 32'h10)
    else $error("strobe high too short");
  cover property ($fell(ALARM_N));
  cover property ($fell(BYTE_READY_FLAG_N));
  cover property ($rose(TEST_STROBE));
endmodule

bind rng_top rng_props #(.NOISE_HALF(NOISE_HALF)) u_props (
  .CLK_SYS(CLK_SYS),
  .RST(RST),
  .FAST_OSC_SELECT(FAST_OSC_SELECT),
  .FAST_OSC_O(FAST_OSC_O),
  .FAST_OSC_OE(FAST_OSC_OE),
  .NOISE_SOURCE_SELECT(NOISE_SOURCE_SELECT),
  .PHASE_NOISE_OSC_I(PHASE_NOISE_OSC_I),
  .PHASE_NOISE_OSC_O(PHASE_NOISE_OSC_O),
  .PHASE_NOISE_OSC_OE(PHASE_NOISE_OSC_OE),
  .SAMPLED_BIT_TEST(SAMPLED_BIT_TEST),
  .TEST_STROBE(TEST_STROBE),
  .BYTE_READY_FLAG_N(BYTE_READY_FLAG_N),
  .ALARM_N(ALARM_N),
  .APB_REQ(APB_REQ),
  .APB_RSP(APB_RSP)
);

// *** dv/tb.sv ***
// Self-checking bench for the random source.
// Drives APB as master; external oscillators from rng_osc_model.
`timescale 1ns/1ps
module tb;
  import rng_pkg::*;
  localparam int NH = 4;
  logic            clk_sys, rst, fast_sel, noise_sel, run, fast_lvl;
  logic            fast_o, fast_oe, fast_x, noise_o, noise_oe, noise_x;
  logic            bit_t, strobe, rdy_n, alarm_n, err;
  logic [31:0]     rd;
  rng_apb_req_type req;
  rng_apb_rsp_type rsp;
  int              miscompares, cmp_count, cyc;
  rng_osc_model #(.HALF(NH)) u_osc (.clk(clk_sys), .run(run), .fast_lvl(fast_lvl), .noise(noise_x), .fast(fast_x));
  rng_top #(.NOISE_HALF(NH)) DUT (.CLK_SYS(clk_sys), .RST(rst), .FAST_OSC_SELECT(fast_sel),
    .FAST_OSC_I(fast_oe ? fast_o : fast_x), .FAST_OSC_O(fast_o), .FAST_OSC_OE(fast_oe),
    .NOISE_SOURCE_SELECT(noise_sel), .PHASE_NOISE_OSC_I(noise_oe ? noise_o : noise_x),
    .PHASE_NOISE_OSC_O(noise_o), .PHASE_NOISE_OSC_OE(noise_oe), .SAMPLED_BIT_TEST(bit_t),
    .TEST_STROBE(strobe), .BYTE_READY_FLAG_N(rdy_n), .ALARM_N(alarm_n), .APB_REQ(req), .APB_RSP(rsp));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic final_report();
    $display("%0d compares, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      final_report();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  // which=1: strobe rise, which=0: ready low; cyc returns cycles waited
  task automatic wait_ev(input logic which, input int lim);
    logic sp, hit;
    sp = strobe;
    cyc = 0;
    do begin
      @(posedge clk_sys);
      cyc++;
      hit = which ? (strobe === 1'b1 && sp === 1'b0) : (rdy_n === 1'b0);
      sp = strobe;
    end while (!hit && cyc < lim);
    if (!hit) begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic t_reset();
    int   n;
    logic lv;
    check(fast_oe, 1);
    check(noise_oe, 1);
    // Internal noise oscillator holds each level for NH cycles
    lv = noise_o;
    n = 0;
    while (noise_o === lv && n < 16) begin
      @(posedge clk_sys);
      n++;
    end
    lv = noise_o;
    n = 0;
    while (noise_o === lv && n < 16) begin
      @(posedge clk_sys);
      n++;
    end
    check(n, NH);
    check(rdy_n, 1);
    check(alarm_n, 1);
    apb(0, 8'h08, 0);
    check(rd, 32'h14);
    apb(0, 8'h0C, 0);
    check(rd, 32'h2F);
    apb(0, 8'h14, 0);
    check(rd, 0);
    $display("test reset done");
  endtask
  task automatic t_ext();
    fast_sel <= 1'b1;
    noise_sel <= 1'b1;
    fast_lvl <= 1'b1;
    run <= 1'b1;
    repeat (6 * NH) @(posedge clk_sys);
    check(fast_oe, 0);
    check(noise_oe, 0);
    check(bit_t, 1);
    fast_lvl <= 1'b0;
    repeat (6 * NH) @(posedge clk_sys);
    check(bit_t, 0);
    fast_lvl <= 1'b1;
    apb(1, 8'h04, 32'h08);
    wait_ev(1, 1000);
    wait_ev(1, 1000);
    check(cyc, 64 * NH);
    apb(0, 8'h18, 0);
    check(rd, 32'hFF);
    fast_lvl <= 1'b0;
    wait_ev(1, 1000);
    wait_ev(1, 1000);
    apb(0, 8'h18, 0);
    check(rd, 32'h00);
    apb(1, 8'h04, 32'h80);
    apb(0, 8'h14, 0);
    check(rd, 0);
    fast_sel <= 1'b0;
    noise_sel <= 1'b0;
    run <= 1'b0;
    $display("test external osc done");
  endtask
  task automatic t_ready();
    int exp;
    logic [31:0] ev;
    apb(1, 8'h08, 0);
    apb(1, 8'h0C, 32'hFF);
    apb(1, 8'h04, 32'h08);
    wait_ev(0, 30000);
    apb(0, 8'h04, 0);
    check(rd[0], 1);
    apb(0, 8'h14, 0);
    check(rd, 67);
    apb(0, 8'h10, 0);
    ev = rd;
    exp = 0;
    for (int i = 0; i < 67; i++) begin
      check(rdy_n, 0);
      apb(0, 8'h00, 0);
      if (rd[3:0] > rd[7:4]) exp++;
    end
    repeat (2) @(posedge clk_sys);
    check(rdy_n, 1);
    check(ev, exp);
    $display("test ready done");
  endtask
  task automatic t_err();
    apb(1, 8'h00, 32'h55);
    check(err, 1);
    repeat (2) @(posedge clk_sys);
    check(alarm_n, 0);
    apb(0, 8'h1C, 0);
    check(err, 1);
    apb(0, 8'h04, 0);
    // Generate enable is still set from the ready test
    check(rd[4:2], 3'b111);
    apb(1, 8'h04, 32'h80);
    check(err, 0);
    repeat (2) @(posedge clk_sys);
    check(alarm_n, 1);
    apb(0, 8'h08, 0);
    check(rd, 0);
    apb(0, 8'h0C, 0);
    check(rd, 32'hFF);
    apb(0, 8'h10, 0);
    check(rd, 0);
    $display("test bus error done");
  endtask
  // Lower limit above 67 events: the run-up test must fail
  task automatic t_fail();
    int n;
    apb(1, 8'h08, 32'h44);
    apb(1, 8'h04, 32'h08);
    n = 0;
    while (alarm_n !== 1'b0 && n < 30000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 30000) begin
      miscompares++;
      final_report();
    end
    check(rdy_n, 1);
    apb(0, 8'h04, 0);
    check(rd[2:0], 3'b010);
    apb(0, 8'h14, 0);
    check(rd, 67);
    apb(1, 8'h04, 32'h80);
    repeat (2) @(posedge clk_sys);
    check(alarm_n, 1);
    $display("test run-up fail done");
  endtask
  initial begin
    rst = 1'b1;
    req = '0;
    fast_sel = 1'b0;
    noise_sel = 1'b0;
    run = 1'b0;
    fast_lvl = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_ext();
    t_ready();
    t_err();
    t_fail();
    final_report();
  end
endmodule

// *** verilog/rng_buf.sv ***
// Two-entry byte buffer between the sampler and the number store.
// Assumes the source pauses while in_ready is low.
`timescale 1ns/1ps
module rng_buf (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       flush,
  // Filling side
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  // Draining side
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [7:0]      out_data
);
  import rng_pkg::*;

  typedef struct packed {
    logic [1:0][7:0] d;
    logic [1:0]      cnt;
  } rng_buf_state_type;

  rng_buf_state_type st_ff;
  rng_buf_state_type nxt_st;
  logic              push;
  logic              pop;

  assign in_ready  = (st_ff.cnt != 2'h2);
  assign out_valid = (st_ff.cnt != 2'h0);
  assign out_data  = st_ff.d[0];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (pop) begin
      nxt_st.d[0] = st_ff.d[1];
    end
    if (push) begin
      if (st_ff.cnt == 2'h0 || (st_ff.cnt == 2'h1 && pop)) begin
        nxt_st.d[0] = in_data;
      end else begin
        nxt_st.d[1] = in_data;
      end
    end
    nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
    if (flush) begin
      nxt_st.cnt = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// *** verilog/rng_consts.svh ***
// Constants of the oscillator-sampling random source: offsets, fields, resets, timing.
// Included by the design modules rng_mem and rng_top; definitions only.
`ifndef RNG_CONSTS_SVH
`define RNG_CONSTS_SVH

// Register byte addresses on APB
`define RNG_OFF_DATA     8'h00
`define RNG_OFF_STATUS   8'h04
`define RNG_OFF_LOWER    8'h08
`define RNG_OFF_UPPER    8'h0C
`define RNG_OFF_EVENTS   8'h10
`define RNG_OFF_COUNT    8'h14
`define RNG_OFF_DIRECT   8'h18

// Status/command register fields
`define RNG_ST_READY     0
`define RNG_ST_FAIL      1
`define RNG_ST_BUSERR    2
`define RNG_ST_GEN       3
`define RNG_ST_ALARM     4
`define RNG_CMD_MRESET   7

// Reset values of the limit registers
`define RNG_LOWER_RST    8'h14
`define RNG_UPPER_RST    8'h2F

// Number geometry: 536 bits as 67 bytes
`define RNG_NUM_BYTES    7'h43
`define RNG_LAST_BYTE    7'h42
`define RNG_BYTE_BITS    8
// Phase-noise edges per latched byte
`define RNG_STROBE_EDGES 6'h20

// Timing
`define RNG_CLK_KHZ      20000
`define RNG_FAST_KHZ     8000
`define RNG_NOISE_KHZ    1
`define RNG_FAST_HALF    ((`RNG_CLK_KHZ / (2 * `RNG_FAST_KHZ)) < 1 ? 1 : (`RNG_CLK_KHZ / (2 * `RNG_FAST_KHZ)))
`define RNG_NOISE_HALF   (`RNG_CLK_KHZ / (2 * `RNG_NOISE_KHZ))

`endif

// *** verilog/rng_mem.sv ***
// Store for the 67 bytes of one random number, registered read port.
// Assumes one write and one read address per cycle; clr zeroes every entry.
`timescale 1ns/1ps
`include "rng_consts.svh"
module rng_mem (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clr,
  // Write port
  input  wire logic       we,
  input  wire logic [6:0] waddr,
  input  wire logic [7:0] wdata,
  // Read port
  input  wire logic [6:0] raddr,
  output logic [7:0]      rdata
);
  import rng_pkg::*;

  typedef struct packed {
    logic [66:0][7:0] d;
    logic [7:0]       q;
  } rng_mem_state_type;

  rng_mem_state_type st_ff;
  rng_mem_state_type nxt_st;
  logic [66:0][7:0]  nxt_ent;

  genvar i;
  generate
    for (i = 0; i < 67; i++) begin : g_ent
      assign nxt_ent[i] = clr ? 8'h00 : ((we && waddr == 7'(i)) ? wdata : st_ff.d[i]);
    end
  endgenerate

  always_comb begin
    nxt_st   = st_ff;
    nxt_st.d = nxt_ent;
    nxt_st.q = (raddr < `RNG_NUM_BYTES) ? st_ff.d[raddr] : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.q;
endmodule

// *** verilog/rng_pkg.sv ***
// Types shared by the random source modules.
// Assumes a plain APB3 master with 32-bit data.
package rng_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rng_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rng_apb_rsp_type;

endpackage

// *** verilog/rng_top.sv ***
// Oscillator-sampling true random source with APB register access.
// Assumes one 20 MHz clock; oscillator pins are sampled as synchronous inputs.
//
// Summary of operation
// [R01] Sample fast oscillator on each phase-noise rising edge; sample drives test pin.
// [R02] Noise select 0: internal phase-noise oscillator driven out; 1: pin is input.
// [R03] Fast select 0: internal 10 MHz oscillator (half the clock) driven out; 1: pin is input.
// [R04] Build a 536-bit number and deliver it as 67 bytes.
// [R05] Run a 4-bit run-up test against host-programmed lower and upper limits.
// [R06] Byte-ready and alarm appear on pins and in the status register.
// [R07] Host can read the direct byte and the accumulated statistics.
// [R08] Byte-ready asserts when test passes with 67 bytes; clears after 67th data read.
// [R09] Alarm asserts on test failure or bus error; only master reset clears it.
// [R10] Master reset clears commands, data, counts; keeps the limit registers.
// [R11] Test strobe rises as each byte is latched; period is 32 noise periods; held high while the buffer is full.
// [R12] One sampled bit shifts in per noise edge; byte is eight consecutive bits; no shift while the buffer is full.
`timescale 1ns/1ps
`include "rng_consts.svh"
module rng_top #(
  parameter int NOISE_HALF = `RNG_NOISE_HALF
) (
  // Clock and reset
  input  wire logic             CLK_SYS,
  input  wire logic             RST,
  // Fast oscillator pin
  input  wire logic             FAST_OSC_SELECT,
  input  wire logic             FAST_OSC_I,
  output logic                  FAST_OSC_O,
  output logic                  FAST_OSC_OE,
  // Phase-noise oscillator pin
  input  wire logic             NOISE_SOURCE_SELECT,
  input  wire logic             PHASE_NOISE_OSC_I,
  output logic                  PHASE_NOISE_OSC_O,
  output logic                  PHASE_NOISE_OSC_OE,
  // Test and flag pins
  output logic                  SAMPLED_BIT_TEST,
  output logic                  TEST_STROBE,
  output logic                  BYTE_READY_FLAG_N,
  output logic                  ALARM_N,
  // Register bus
  input  rng_pkg::rng_apb_req_type APB_REQ,
  output rng_pkg::rng_apb_rsp_type APB_RSP
);
  import rng_pkg::*;

  localparam logic [3:0]  FAST_LAST  = 4'(`RNG_FAST_HALF - 1);
  localparam logic [15:0] NOISE_LAST = 16'(NOISE_HALF - 1);

  typedef struct packed {
    logic [3:0]  fast_cnt;
    logic        fast_osc;
    logic [15:0] noise_cnt;
    logic        noise_osc;
    logic        noise_prev;
    logic        sample;
    logic [7:0]  shift;
    logic [4:0]  edge_cnt;
    logic [7:0]  direct;
    logic        gen_en;
    logic [6:0]  wr_idx;
    logic [6:0]  rd_idx;
    logic [7:0]  events;
    logic        ready;
    logic        fail;
    logic        bus_err;
    logic [7:0]  lower;
    logic [7:0]  upper;
    logic [31:0] prdata;
    logic        slverr;
  } rng_state_type;

  rng_state_type st_ff;
  rng_state_type nxt_st;

  logic       sel_fast;
  logic       sel_noise;
  logic       noise_rise;
  logic       alarm;
  logic       buf_in_valid;
  logic       buf_in_ready;
  logic [7:0] buf_in_data;
  logic       buf_out_valid;
  logic       buf_out_ready;
  logic [7:0] buf_out_data;
  logic       mem_we;
  logic [7:0] mem_rdata;
  logic       setup;
  logic       access;
  logic       mreset;
  logic [7:0] addr;

  // Oscillator source selection; enables stay high while this end drives
  assign sel_fast           = FAST_OSC_SELECT ? FAST_OSC_I : st_ff.fast_osc; // R03
  assign FAST_OSC_O         = st_ff.fast_osc; // R03
  assign FAST_OSC_OE        = ~FAST_OSC_SELECT; // R03
  assign sel_noise          = NOISE_SOURCE_SELECT ? PHASE_NOISE_OSC_I : st_ff.noise_osc; // R02
  assign PHASE_NOISE_OSC_O  = st_ff.noise_osc; // R02
  assign PHASE_NOISE_OSC_OE = ~NOISE_SOURCE_SELECT; // R02
  assign noise_rise         = sel_noise & ~st_ff.noise_prev;

  // Pins
  assign SAMPLED_BIT_TEST  = st_ff.sample; // R01
  assign TEST_STROBE       = ~st_ff.edge_cnt[4]; // R11
  assign alarm             = st_ff.fail | st_ff.bus_err; // R09
  assign BYTE_READY_FLAG_N = ~st_ff.ready; // R06
  assign ALARM_N           = ~alarm; // R06

  // Byte leaves the sampler on the last of 32 noise edges; a full buffer pauses the count
  assign buf_in_valid = noise_rise & (st_ff.edge_cnt == 5'h1F); // R11
  assign buf_in_data  = {st_ff.shift[6:0], sel_fast}; // R12

  // Store drains only while collecting; stalls here back up into the sampler
  assign buf_out_ready = st_ff.gen_en & ~st_ff.ready & ~alarm & (st_ff.wr_idx < `RNG_NUM_BYTES);
  assign mem_we        = buf_out_valid & buf_out_ready; // R04

  // APB phases
  assign addr   = APB_REQ.paddr;
  assign setup  = APB_REQ.psel & ~APB_REQ.penable;
  assign access = APB_REQ.psel & APB_REQ.penable;
  assign mreset = access & APB_REQ.pwrite & ~st_ff.slverr & (addr == `RNG_OFF_STATUS)
                & APB_REQ.pwdata[`RNG_CMD_MRESET];

  // Zero wait states: read data was prepared in the setup cycle
  assign APB_RSP.prdata  = st_ff.prdata;
  assign APB_RSP.pready  = APB_REQ.penable;
  assign APB_RSP.pslverr = access & st_ff.slverr;

  rng_buf u_buf (
    .clk       (CLK_SYS),
    .rst       (RST),
    .flush     (mreset),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  rng_mem u_mem (
    .clk   (CLK_SYS),
    .rst   (RST),
    .clr   (mreset),
    .we    (mem_we),
    .waddr (st_ff.wr_idx),
    .wdata (buf_out_data),
    .raddr (st_ff.rd_idx),
    .rdata (mem_rdata)
  );

  always_comb begin
    nxt_st = st_ff;

    // Internal oscillators as free-running counter-driven square waves
    if (st_ff.fast_cnt == FAST_LAST) begin
      nxt_st.fast_cnt = 4'h0;
      nxt_st.fast_osc = ~st_ff.fast_osc; // R03
    end else begin
      nxt_st.fast_cnt = st_ff.fast_cnt + 4'h1;
    end
    if (st_ff.noise_cnt == NOISE_LAST) begin
      nxt_st.noise_cnt = 16'h0000;
      nxt_st.noise_osc = ~st_ff.noise_osc; // R02
    end else begin
      nxt_st.noise_cnt = st_ff.noise_cnt + 16'h0001;
    end
    nxt_st.noise_prev = sel_noise;

    // Sampling flip-flop and shift register
    if (noise_rise) begin
      nxt_st.sample = sel_fast; // R01
      if (buf_in_ready) begin
        nxt_st.shift    = buf_in_data; // R12
        nxt_st.edge_cnt = st_ff.edge_cnt + 5'h01; // R11
        if (buf_in_valid) begin
          nxt_st.direct = buf_in_data; // R07
        end
      end
    end

    // Collection and run-up counting; an event is a later nibble above the earlier one
    if (mem_we) begin
      nxt_st.wr_idx = st_ff.wr_idx + 7'h01; // R04
      if (buf_out_data[3:0] > buf_out_data[7:4]) begin
        nxt_st.events = st_ff.events + 8'h01; // R05
      end
    end

    // Verdict once the whole number is stored
    if (st_ff.gen_en && !st_ff.ready && !st_ff.fail && st_ff.wr_idx == `RNG_NUM_BYTES) begin
      if (st_ff.events >= st_ff.lower && st_ff.events <= st_ff.upper) begin
        nxt_st.ready  = 1'b1; // R08
        nxt_st.rd_idx = 7'h00;
      end else begin
        nxt_st.fail = 1'b1; // R05
      end
    end

    // Setup cycle: decode and stage read data
    if (setup) begin
      nxt_st.prdata = 32'h0000_0000;
      nxt_st.slverr = 1'b0;
      case (addr)
        `RNG_OFF_DATA: begin
          nxt_st.slverr = APB_REQ.pwrite;
          nxt_st.prdata = st_ff.ready ? {24'h00_0000, mem_rdata} : 32'h0000_0000; // R04
        end
        `RNG_OFF_STATUS: begin
          nxt_st.prdata[`RNG_ST_READY]  = st_ff.ready; // R06
          nxt_st.prdata[`RNG_ST_FAIL]   = st_ff.fail;
          nxt_st.prdata[`RNG_ST_BUSERR] = st_ff.bus_err;
          nxt_st.prdata[`RNG_ST_GEN]    = st_ff.gen_en;
          nxt_st.prdata[`RNG_ST_ALARM]  = alarm; // R06
        end
        `RNG_OFF_LOWER: begin
          nxt_st.prdata = {24'h00_0000, st_ff.lower};
        end
        `RNG_OFF_UPPER: begin
          nxt_st.prdata = {24'h00_0000, st_ff.upper};
        end
        `RNG_OFF_EVENTS: begin
          nxt_st.slverr = APB_REQ.pwrite;
          nxt_st.prdata = {24'h00_0000, st_ff.events}; // R07
        end
        `RNG_OFF_COUNT: begin
          nxt_st.slverr = APB_REQ.pwrite;
          nxt_st.prdata = {25'h000_0000, st_ff.wr_idx}; // R07
        end
        `RNG_OFF_DIRECT: begin
          nxt_st.slverr = APB_REQ.pwrite;
          nxt_st.prdata = {24'h00_0000, st_ff.direct}; // R07
        end
        default: begin
          nxt_st.slverr = 1'b1;
        end
      endcase
    end

    // Access cycle: the transfer completes here
    if (access) begin
      if (st_ff.slverr) begin
        nxt_st.bus_err = 1'b1; // R09
      end else if (APB_REQ.pwrite) begin
        case (addr)
          `RNG_OFF_STATUS: nxt_st.gen_en = APB_REQ.pwdata[`RNG_ST_GEN];
          `RNG_OFF_LOWER:  nxt_st.lower  = APB_REQ.pwdata[7:0]; // R05
          `RNG_OFF_UPPER:  nxt_st.upper  = APB_REQ.pwdata[7:0]; // R05
          default:         nxt_st.gen_en = st_ff.gen_en;
        endcase
      end else if (addr == `RNG_OFF_DATA && st_ff.ready) begin
        nxt_st.rd_idx = st_ff.rd_idx + 7'h01;
        if (st_ff.rd_idx == `RNG_LAST_BYTE) begin
          // Number consumed: start collecting the next one
          nxt_st.ready  = 1'b0; // R08
          nxt_st.rd_idx = 7'h00;
          nxt_st.wr_idx = 7'h00;
          nxt_st.events = 8'h00;
        end
      end
    end

    // Master reset keeps the limits so software need not reload them
    if (mreset) begin
      nxt_st.gen_en   = 1'b0; // R10
      nxt_st.wr_idx   = 7'h00; // R10
      nxt_st.rd_idx   = 7'h00;
      nxt_st.events   = 8'h00; // R10
      nxt_st.ready    = 1'b0;
      nxt_st.fail     = 1'b0; // R09
      nxt_st.bus_err  = 1'b0; // R09
      nxt_st.direct   = 8'h00; // R10
      nxt_st.shift    = 8'h00;
      nxt_st.edge_cnt = 5'h00;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st_ff       <= '0;
      st_ff.lower <= `RNG_LOWER_RST;
      st_ff.upper <= `RNG_UPPER_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule
